// file: bench/plbc_test_set.sv
/*
  Test-set model on the client and trunk lines: fresh random lanes each cycle.
  Assumes the bench seeds $urandom once and freezes lanes with hold_i.
*/
`timescale 1ns/1ps

module plbc_test_set (
  input  wire logic       clock_i,          // System clock
  input  wire logic       hold_i,           // Freeze lanes for compares
  output logic [3:0][7:0] client_rx_o = '0, // Toward client lines
  output logic [3:0][7:0] trunk_rx_o  = '0  // Toward trunk lanes
);
  // New words every cycle while hold_i is low, so a stuck lane never passes for a match
  always @(posedge clock_i) begin
    if (!hold_i) begin
      client_rx_o <= {$urandom};
      trunk_rx_o  <= {$urandom};
    end
  end
endmodule : plbc_test_set

// file: bench/test_port_loopback_control.sv
/*
  Self-checking bench of the port loopback controller, APB master included.
  Assumes the design files and plbc_test_set.sv are compiled before it.
*/
`timescale 1ns/1ps

module test_port_loopback_control;
  logic clock_i = 0, arst_n_i = 0, psel_i = 0, penable_i = 0, pwrite_i = 0, hold = 0;
  logic [11:0] paddr_i = '0;
  logic [31:0] pwdata_i = '0, prdata_o, rd;
  logic [3:0]  pstrb_i = 4'hf;
  logic        pready_o, pslverr_o, loop_complete_o, err;
  logic [3:0][7:0] client_rx_i, client_tx_o, trunk_rx_i, trunk_tx_o;
  logic [4:0]  alarm_i = '0, alarm_o, term_o, fac_o, asm_o;
  int          error_cnt = 0, tests_run = 0;

  plbc_loopback_ctrl DUT (.clock_i(clock_i), .arst_n_i(arst_n_i), .psel_i(psel_i),
    .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i),
    .pstrb_i(pstrb_i), .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
    .client_rx_i(client_rx_i), .client_tx_o(client_tx_o), .trunk_rx_i(trunk_rx_i),
    .trunk_tx_o(trunk_tx_o), .alarm_i(alarm_i), .alarm_o(alarm_o),
    .terminal_loop_condition_o(term_o), .facility_loop_condition_o(fac_o),
    .alarm_suppressed_maintenance_o(asm_o), .loop_complete_o(loop_complete_o));
  plbc_test_set u_set (.clock_i(clock_i), .hold_i(hold), .client_rx_o(client_rx_i),
    .trunk_rx_o(trunk_rx_i));

  // Free-running 100 MHz clock
  always #5 clock_i = ~clock_i;

  task automatic stop_test;
    if (error_cnt == 0 && tests_run > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : stop_test

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      error_cnt++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // One APB transfer; request held until pready is seen at an edge
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    psel_i <= 1'b1; pwrite_i <= wr; paddr_i <= a; pwdata_i <= d;
    @(posedge clock_i) penable_i <= 1'b1;
    do @(posedge clock_i); while (pready_o !== 1'b1);
    rd = prdata_o;
    err = pslverr_o;
    psel_i <= 1'b0; penable_i <= 1'b0;
    @(posedge clock_i);
  endtask : apb

  // Register word holding one 2-bit field per port
  function automatic logic [31:0] f2(input int p, input logic [1:0] v);
    return 32'(v) << (2 * p);
  endfunction : f2

  task automatic settle;
    repeat (6) @(posedge clock_i);
  endtask : settle

  // Watchdog: the sequence needs well under a thousand cycles
  initial begin
    #100us;
    error_cnt++;
    stop_test();
  end

  initial begin
    void'($urandom(32'h144e9c50));
    repeat (4) @(posedge clock_i);
    arst_n_i <= 1'b1;
    repeat (3) @(posedge clock_i);
    apb(0, 12'h000, 0); chk(rd, 32'h0);
    apb(0, 12'h004, 0); chk(rd, 32'h0);
    apb(0, 12'h014, 0); chk(err, 1'b1);
    chk(rd, 32'h0);
    // Transponder, clients 0..2 provisioned, clients 0 and 3 in maintenance
    apb(1, 12'h000, 32'h0); apb(1, 12'h004, 32'h70); apb(1, 12'h00c, 32'h41);
    apb(1, 12'h008, f2(3, 2'b11)); apb(0, 12'h008, 0); chk(rd, 0);
    apb(1, 12'h008, f2(0, 2'b10)); apb(0, 12'h008, 0); chk(rd, 0);
    apb(1, 12'h008, f2(1, 2'b01)); apb(0, 12'h008, 0); chk(rd, 0);
    hold <= 1'b1;
    apb(1, 12'h008, f2(0, 2'b11)); apb(0, 12'h00c, 0); chk(rd, 32'h43);
    alarm_i <= 5'h1f;
    settle();
    chk({term_o, fac_o, asm_o, loop_complete_o}, {5'h01, 5'h00, 5'h01, 1'b1});
    chk(alarm_o, 5'h1e);
    chk(trunk_tx_o[0], trunk_rx_i[0]);
    chk(client_tx_o[0], trunk_rx_i[0]);
    chk(trunk_tx_o[1], client_rx_i[1]);
    apb(1, 12'h000, 32'h4); settle(); chk({alarm_o, asm_o}, {5'h1f, 5'h00});
    apb(1, 12'h00c, 32'h143); settle(); chk(loop_complete_o, 0);
    apb(1, 12'h000, 32'h5); settle(); chk(loop_complete_o, 1);
    apb(1, 12'h008, f2(0, 2'b01)); apb(0, 12'h008, 0); chk(rd, 32'h3);
    apb(1, 12'h008, 0); apb(0, 12'h00c, 0); settle(); chk(rd, 32'h141);
    chk(term_o, 5'h0);
    // Client 0 facility loop, terminated toward the trunk
    apb(1, 12'h008, f2(0, 2'b01)); settle(); chk(fac_o, 5'h01);
    chk(client_tx_o[0], client_rx_i[0]);
    chk(trunk_tx_o[0], 8'hff);
    apb(1, 12'h008, 0);
    // Add-drop card, client 1 carries GbE
    hold <= 1'b0; alarm_i <= 5'($urandom);
    apb(1, 12'h000, 32'h2); apb(1, 12'h004, 32'h72); apb(1, 12'h00c, 32'h145);
    apb(1, 12'h008, 32'h0f); settle();
    chk(client_tx_o[0], 8'hff);
    chk(client_tx_o[1], 8'h00);
    apb(1, 12'h008, 0); apb(1, 12'h008, f2(4, 2'b01)); hold <= 1'b1; settle();
    chk({client_tx_o[2], client_tx_o[1], fac_o}, {8'hff, 8'h00, 5'h10});
    chk(trunk_tx_o[3], trunk_rx_i[3]);
    apb(1, 12'h008, 0); apb(1, 12'h008, f2(4, 2'b11)); settle();
    chk(loop_complete_o, 0);
    chk(trunk_tx_o[2], client_rx_i[2]);
    chk(client_tx_o[2], client_rx_i[2]);
    apb(1, 12'h00c, 32'h300); settle(); chk(loop_complete_o, 1);
    stop_test();
  end
endmodule : test_port_loopback_control

// file: verilog/plbc_cfg.svh
/*
  Constants of the port loopback controller: port counts, lane width,
  register offsets, field positions, reset values and fill patterns.
  Assumes inclusion by bare name from the package and the design files.
*/
`ifndef PLBC_CFG_SVH
`define PLBC_CFG_SVH

// Port layout: clients 0..3, trunk last
`define PLBC_NUM_CLIENTS    4
`define PLBC_NUM_PORTS      5
`define PLBC_TRUNK_IDX      4
`define PLBC_LANE_W         8
`define PLBC_ADDR_W         12

// Register byte offsets
`define PLBC_OFS_CTRL       12'h000
`define PLBC_OFS_CLIENT_CFG 12'h004
`define PLBC_OFS_LOOP_MODE  12'h008
`define PLBC_OFS_SVC_STATE  12'h00c
`define PLBC_OFS_STATUS     12'h010

// Control register fields
`define PLBC_CTRL_CARD_LSB  0
`define PLBC_CTRL_ALM_BIT   2
`define PLBC_CTRL_TBR_BIT   3
`define PLBC_CTRL_MASK      32'h0000_000f

// Client configuration fields, one bit per client
`define PLBC_CCFG_GE_LSB    0
`define PLBC_CCFG_PROV_LSB  4
`define PLBC_CCFG_BR_LSB    8
`define PLBC_CCFG_MASK      32'h0000_0fff

// Status fields, one bit per port, plus a single completeness bit
`define PLBC_ST_TERM_LSB    0
`define PLBC_ST_FAC_LSB     5
`define PLBC_ST_ASM_LSB     10
`define PLBC_ST_CPLT_BIT    15

// Reset values
`define PLBC_CTRL_RST       32'h0000_0000
`define PLBC_CCFG_RST       32'h0000_0000

// Downstream fill patterns
`define PLBC_AIS_FILL       8'hff
`define PLBC_SQUELCH_FILL   8'h00

`endif

// file: verilog/plbc_lane.sv
/*
  One direction pair of a port lane: line side and core side, with
  facility and terminal loopback steering and downstream fill.
  Assumes the steering bundle comes from registers of the same clock.
*/
`timescale 1ns/1ps
`include "plbc_cfg.svh"

module plbc_lane (
  input  wire logic                       clock_i,    // System clock
  input  wire logic                       rst_n_i,    // Synchronous-release reset
  input  wire plbc_pkg::plbc_lane_cfg_type cfg_i,     // Loop steering
  input  wire logic [`PLBC_LANE_W-1:0]    line_rx_i,  // From the span
  input  wire logic [`PLBC_LANE_W-1:0]    core_in_i,  // From the far side of card
  output logic      [`PLBC_LANE_W-1:0]    line_tx_o,  // Toward the span
  output logic      [`PLBC_LANE_W-1:0]    core_out_o  // Toward far side of card
);

  // Line transmit: facility turns the span signal outward
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      line_tx_o <= '0;
    end else if (cfg_i.mode == plbc_pkg::PLBC_LOOP_FACILITY) begin
      line_tx_o <= line_rx_i;
    end else if (cfg_i.line_fill) begin
      line_tx_o <= cfg_i.fill;
    end else begin
      line_tx_o <= core_in_i;
    end
  end

  // Core output: terminal returns inward; terminated facility sends fill
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      core_out_o <= '0;
    end else if (cfg_i.mode == plbc_pkg::PLBC_LOOP_TERMINAL) begin
      core_out_o <= core_in_i;
    end else if (cfg_i.mode == plbc_pkg::PLBC_LOOP_FACILITY && !cfg_i.fac_bridge) begin
      core_out_o <= cfg_i.fill;
    end else begin
      core_out_o <= line_rx_i;
    end
  end

endmodule : plbc_lane

// file: verilog/plbc_loopback_ctrl.sv
/*
  Port loopback controller top: APB register file, per-port loopback mode
  and service state, static client-to-trunk lane mapping, fill insertion,
  loop conditions and alarm suppression.
  Assumes APB master in the same clock domain; line data synchronous.
*/
// Behaviour
// - Terminated loopback returns signal to origin only, nothing forwarded.
// - Bridged loopback returns signal to origin and forwards it too.
// - Bridged inserts no AIS downstream; terminated inserts AIS downstream, squelch fill for GbE clients.
// - Terminal loopbacks are bridged, except client terminal loops on the add-drop card.
// - Transponder client terminal loop needs trunk in service.
// - Muxponder client loop places no demand on other ports.
// - Add-drop card: SONET client terminal loop sends path AIS forward.
// - Add-drop card: GbE client terminal loop squelches client output.
// - Trunk terminal loop affects all clients; clients must be in service.
// - Add-drop card: trunk facility loop sends AIS on SONET clients.
// - Add-drop card: trunk facility loop squelches all GbE clients.
// - Add-drop card: trunk terminal loop still forwards downstream.
// - Client facility loop on transponder needs trunk unlocked-enabled.
// - Trunk terminal loop needs clients unlocked-enabled for completeness.
// - Report per-port terminal or facility loop condition while active.
// - Suppress looped port alarms and flag it, unless alarms allowed.
// - Clients map statically to trunk lanes, no cross-connect.
// - Client loop config refused until pluggable module provisioned.
// - Loop created only from maintenance state; then loop-maintenance.
// - Facility returns signal toward span; terminal returns it inward.
`timescale 1ns/1ps
`include "plbc_cfg.svh"

module plbc_loopback_ctrl (
  input  wire logic                                       clock_i,   // 100 MHz
  input  wire logic                                       arst_n_i,  // Async reset
  input  wire logic                                       psel_i,    // APB select
  input  wire logic                                       penable_i, // APB enable
  input  wire logic                                       pwrite_i,  // APB write
  input  wire logic [`PLBC_ADDR_W-1:0]                    paddr_i,   // APB address
  input  wire logic [31:0]                                pwdata_i,  // APB wdata
  input  wire logic [3:0]                                 pstrb_i,   // Byte lanes
  output logic      [31:0]                                prdata_o,  // APB rdata
  output logic                                            pready_o,  // APB ready
  output logic                                            pslverr_o, // Unmapped
  input  wire logic [`PLBC_NUM_CLIENTS-1:0][`PLBC_LANE_W-1:0] client_rx_i, // Client in
  output wire logic [`PLBC_NUM_CLIENTS-1:0][`PLBC_LANE_W-1:0] client_tx_o, // Client out
  input  wire logic [`PLBC_NUM_CLIENTS-1:0][`PLBC_LANE_W-1:0] trunk_rx_i,  // Trunk in
  output wire logic [`PLBC_NUM_CLIENTS-1:0][`PLBC_LANE_W-1:0] trunk_tx_o,  // Trunk out
  input  wire logic [`PLBC_NUM_PORTS-1:0]                 alarm_i,   // Raw alarms
  output logic      [`PLBC_NUM_PORTS-1:0]                 alarm_o,   // Gated alarms
  output logic      [`PLBC_NUM_PORTS-1:0]                 terminal_loop_condition_o,
  output logic      [`PLBC_NUM_PORTS-1:0]                 facility_loop_condition_o,
  output logic      [`PLBC_NUM_PORTS-1:0]                 alarm_suppressed_maintenance_o,
  output logic                                            loop_complete_o // Preconds met
);

  localparam int NC = `PLBC_NUM_CLIENTS;
  localparam int NP = `PLBC_NUM_PORTS;
  localparam int TR = `PLBC_TRUNK_IDX;

  logic                       rst_n;
  logic [31:0]                ctrl_reg;
  logic [31:0]                ccfg_reg;
  logic [31:0]                prdata_reg;
  logic [31:0]                rd_data;
  logic [31:0]                wmask;
  logic [31:0]                mode_word;
  logic [31:0]                svc_word;
  logic [31:0]                mode_rd;
  logic [31:0]                svc_rd;
  logic                       wr_fire;
  logic                       addr_hit;
  plbc_pkg::plbc_mode_type    mode_reg  [NP];
  plbc_pkg::plbc_mode_type    mode_next [NP];
  plbc_pkg::plbc_svc_type     svc_reg   [NP];
  plbc_pkg::plbc_svc_type     svc_next  [NP];
  plbc_pkg::plbc_card_type    card;
  plbc_pkg::plbc_lane_cfg_type client_cfg [NC];
  plbc_pkg::plbc_lane_cfg_type trunk_cfg  [NC];
  logic [`PLBC_LANE_W-1:0]    client_core [NC];
  logic [`PLBC_LANE_W-1:0]    trunk_core  [NC];
  logic [NP-1:0]              looped;
  logic                       alarm_in_loop;
  logic                       loop_complete_next;

  plbc_rst_sync u_rst_sync (
    .clock_i  (clock_i),
    .arst_n_i (arst_n_i),
    .rst_n_o  (rst_n)
  );

  // APB decode; zero wait states keep the master simple
  assign pready_o  = 1'b1;
  assign wr_fire   = psel_i & penable_i & pwrite_i;
  assign addr_hit  = (paddr_i == `PLBC_OFS_CTRL) || (paddr_i == `PLBC_OFS_CLIENT_CFG) ||
                     (paddr_i == `PLBC_OFS_LOOP_MODE) || (paddr_i == `PLBC_OFS_SVC_STATE) ||
                     (paddr_i == `PLBC_OFS_STATUS);
  assign pslverr_o = psel_i & penable_i & ~addr_hit;
  assign wmask     = {{8{pstrb_i[3]}}, {8{pstrb_i[2]}}, {8{pstrb_i[1]}}, {8{pstrb_i[0]}}};
  assign prdata_o  = prdata_reg;

  assign card          = plbc_pkg::plbc_card_type'(ctrl_reg[`PLBC_CTRL_CARD_LSB +: 2]);
  assign alarm_in_loop = ctrl_reg[`PLBC_CTRL_ALM_BIT];

  // Static configuration registers
  always_ff @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_reg <= `PLBC_CTRL_RST;
      ccfg_reg <= `PLBC_CCFG_RST;
    end else if (wr_fire && paddr_i == `PLBC_OFS_CTRL) begin
      ctrl_reg <= ((ctrl_reg & ~wmask) | (pwdata_i & wmask)) & `PLBC_CTRL_MASK;
    end else if (wr_fire && paddr_i == `PLBC_OFS_CLIENT_CFG) begin
      ccfg_reg <= ((ccfg_reg & ~wmask) | (pwdata_i & wmask)) & `PLBC_CCFG_MASK;
    end
  end

  // Packed views of mode and state for readback and merging
  always_comb begin
    mode_rd = '0;
    svc_rd  = '0;
    for (int p = 0; p < NP; p++) begin
      mode_rd[2*p +: 2] = mode_reg[p];
      svc_rd[2*p +: 2]  = svc_reg[p];
    end
    mode_word = (mode_rd & ~wmask) | (pwdata_i & wmask);
    svc_word  = (svc_rd & ~wmask) | (pwdata_i & wmask);
  end

  // Loop mode requests: illegal or mode-to-mode jumps are ignored
  always_comb begin
    for (int p = 0; p < NP; p++) begin
      mode_next[p] = mode_reg[p];
      svc_next[p]  = svc_reg[p];
      if (wr_fire && paddr_i == `PLBC_OFS_LOOP_MODE) begin
        if (mode_word[2*p +: 2] == plbc_pkg::PLBC_LOOP_NONE &&
            mode_reg[p] != plbc_pkg::PLBC_LOOP_NONE) begin
          mode_next[p] = plbc_pkg::PLBC_LOOP_NONE;
          svc_next[p]  = plbc_pkg::PLBC_OUT_OF_SERVICE_MAINT_STATE;
        end else if ((mode_word[2*p +: 2] == plbc_pkg::PLBC_LOOP_FACILITY ||
                      mode_word[2*p +: 2] == plbc_pkg::PLBC_LOOP_TERMINAL) &&
                     mode_reg[p] == plbc_pkg::PLBC_LOOP_NONE &&
                     svc_reg[p] == plbc_pkg::PLBC_OUT_OF_SERVICE_MAINT_STATE &&
                     (p == TR || ccfg_reg[`PLBC_CCFG_PROV_LSB + (p % NC)])) begin
          mode_next[p] = plbc_pkg::plbc_mode_type'(mode_word[2*p +: 2]);
          svc_next[p]  = plbc_pkg::PLBC_OUT_OF_SERVICE_LOOP_MAINT_STATE;
        end
      end else if (wr_fire && paddr_i == `PLBC_OFS_SVC_STATE &&
                   mode_reg[p] == plbc_pkg::PLBC_LOOP_NONE &&
                   svc_word[2*p +: 2] != plbc_pkg::PLBC_OUT_OF_SERVICE_LOOP_MAINT_STATE) begin
        // Loop-maintenance is entered only by creating a loop
        svc_next[p] = plbc_pkg::plbc_svc_type'(svc_word[2*p +: 2]);
      end
    end
  end

  // Mode and service state per port
  always_ff @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) begin
      for (int p = 0; p < NP; p++) begin
        mode_reg[p] <= plbc_pkg::PLBC_LOOP_NONE;
        svc_reg[p]  <= plbc_pkg::PLBC_IN_SERVICE_NORMAL_STATE;
      end
    end else begin
      for (int p = 0; p < NP; p++) begin
        mode_reg[p] <= mode_next[p];
        svc_reg[p]  <= svc_next[p];
      end
    end
  end

  // Read data captured in the setup phase so prdata comes from a flop
  always_comb begin
    rd_data = 32'h0000_0000;
    unique case (paddr_i)
      `PLBC_OFS_CTRL:       rd_data = ctrl_reg;
      `PLBC_OFS_CLIENT_CFG: rd_data = ccfg_reg;
      `PLBC_OFS_LOOP_MODE:  rd_data = mode_rd;
      `PLBC_OFS_SVC_STATE:  rd_data = svc_rd;
      `PLBC_OFS_STATUS: begin
        rd_data[`PLBC_ST_TERM_LSB +: NP] = terminal_loop_condition_o;
        rd_data[`PLBC_ST_FAC_LSB +: NP]  = facility_loop_condition_o;
        rd_data[`PLBC_ST_ASM_LSB +: NP]  = alarm_suppressed_maintenance_o;
        rd_data[`PLBC_ST_CPLT_BIT]       = loop_complete_o;
      end
      default:              rd_data = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) begin
      prdata_reg <= 32'h0000_0000;
    end else if (psel_i && !penable_i && !pwrite_i) begin
      prdata_reg <= rd_data;
    end
  end

  // Lane steering: add-drop card fills client outputs in two cases
  always_comb begin
    for (int k = 0; k < NC; k++) begin
      client_cfg[k].mode       = mode_reg[k];
      client_cfg[k].fac_bridge = ccfg_reg[`PLBC_CCFG_BR_LSB + k];
      client_cfg[k].fill       = ccfg_reg[`PLBC_CCFG_GE_LSB + k] ?
                                 `PLBC_SQUELCH_FILL : `PLBC_AIS_FILL;
      client_cfg[k].line_fill  = (card == plbc_pkg::PLBC_ADD_DROP_CARD) &&
                                 (mode_reg[k] == plbc_pkg::PLBC_LOOP_TERMINAL ||
                                  mode_reg[TR] == plbc_pkg::PLBC_LOOP_FACILITY);
      trunk_cfg[k].mode        = mode_reg[TR];
      trunk_cfg[k].fac_bridge  = ctrl_reg[`PLBC_CTRL_TBR_BIT];
      trunk_cfg[k].fill        = `PLBC_AIS_FILL;
      trunk_cfg[k].line_fill   = 1'b0;  // Terminal on trunk still forwards
    end
  end

  // Fixed client k <-> trunk lane k pairing, no cross-connect
  for (genvar k = 0; k < NC; k++) begin : g_lane
    plbc_lane u_client (
      .clock_i    (clock_i),
      .rst_n_i    (rst_n),
      .cfg_i      (client_cfg[k]),
      .line_rx_i  (client_rx_i[k]),
      .core_in_i  (trunk_core[k]),
      .line_tx_o  (client_tx_o[k]),
      .core_out_o (client_core[k])
    );
    plbc_lane u_trunk (
      .clock_i    (clock_i),
      .rst_n_i    (rst_n),
      .cfg_i      (trunk_cfg[k]),
      .line_rx_i  (trunk_rx_i[k]),
      .core_in_i  (client_core[k]),
      .line_tx_o  (trunk_tx_o[k]),
      .core_out_o (trunk_core[k])
    );
  end

  // Companion port preconditions; muxponder clients place none
  always_comb begin
    loop_complete_next = 1'b1;
    for (int p = 0; p < NP; p++) begin
      looped[p] = (mode_reg[p] != plbc_pkg::PLBC_LOOP_NONE);
    end
    if (mode_reg[TR] == plbc_pkg::PLBC_LOOP_TERMINAL) begin
      for (int k = 0; k < NC; k++) begin
        if (svc_reg[k] != plbc_pkg::PLBC_IN_SERVICE_NORMAL_STATE) begin
          loop_complete_next = 1'b0;
        end
      end
    end
    if (card == plbc_pkg::PLBC_TRANSPONDER_CARD && (|looped[NC-1:0]) &&
        svc_reg[TR] != plbc_pkg::PLBC_IN_SERVICE_NORMAL_STATE) begin
      loop_complete_next = 1'b0;
    end
  end

  // Conditions, alarm gating and completeness flag
  always_ff @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) begin
      terminal_loop_condition_o      <= '0;
      facility_loop_condition_o      <= '0;
      alarm_suppressed_maintenance_o <= '0;
      alarm_o                        <= '0;
      loop_complete_o                <= 1'b1;
    end else begin
      for (int p = 0; p < NP; p++) begin
        terminal_loop_condition_o[p] <= (mode_reg[p] == plbc_pkg::PLBC_LOOP_TERMINAL);
        facility_loop_condition_o[p] <= (mode_reg[p] == plbc_pkg::PLBC_LOOP_FACILITY);
      end
      alarm_suppressed_maintenance_o <= looped & {NP{~alarm_in_loop}};
      alarm_o                        <= alarm_i & ~(looped & {NP{~alarm_in_loop}});
      loop_complete_o                <= loop_complete_next;
    end
  end

  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!rst_n);

  a_single_mode: assert property (
    (terminal_loop_condition_o & facility_loop_condition_o) == '0)
    else $error("port shows both loop conditions");

  a_loop_entry_state: assert property (
    wr_fire && paddr_i == `PLBC_OFS_LOOP_MODE && pwdata_i[1:0] == 2'b01 && pstrb_i[0] &&
    mode_reg[0] == plbc_pkg::PLBC_LOOP_NONE && ccfg_reg[`PLBC_CCFG_PROV_LSB] &&
    svc_reg[0] == plbc_pkg::PLBC_OUT_OF_SERVICE_MAINT_STATE
    |=> mode_reg[0] == plbc_pkg::PLBC_LOOP_FACILITY &&
        svc_reg[0] == plbc_pkg::PLBC_OUT_OF_SERVICE_LOOP_MAINT_STATE ##1
        facility_loop_condition_o[0])
    else $error("facility loop not entered on client 0");

  a_unprov_refused: assert property (
    wr_fire && paddr_i == `PLBC_OFS_LOOP_MODE && !ccfg_reg[`PLBC_CCFG_PROV_LSB + 3] &&
    mode_reg[3] == plbc_pkg::PLBC_LOOP_NONE
    |=> mode_reg[3] == plbc_pkg::PLBC_LOOP_NONE)
    else $error("loop set on unprovisioned client");

  a_release_restores: assert property (
    wr_fire && paddr_i == `PLBC_OFS_LOOP_MODE && pstrb_i[1] && pwdata_i[9:8] == 2'b00 &&
    mode_reg[TR] != plbc_pkg::PLBC_LOOP_NONE
    |=> mode_reg[TR] == plbc_pkg::PLBC_LOOP_NONE &&
        svc_reg[TR] == plbc_pkg::PLBC_OUT_OF_SERVICE_MAINT_STATE)
    else $error("trunk loop release did not restore");

  a_fac_returns: assert property (
    mode_reg[0] == plbc_pkg::PLBC_LOOP_FACILITY |=> client_tx_o[0] == $past(client_rx_i[0]))
    else $error("facility loop not returned to span");

  a_fac_terminated: assert property (
    mode_reg[TR] == plbc_pkg::PLBC_LOOP_FACILITY && !ctrl_reg[`PLBC_CTRL_TBR_BIT]
    |=> trunk_core[0] == `PLBC_AIS_FILL)
    else $error("terminated trunk loop leaked downstream");

  a_term_bridged: assert property (
    mode_reg[0] == plbc_pkg::PLBC_LOOP_TERMINAL && card != plbc_pkg::PLBC_ADD_DROP_CARD
    |=> client_tx_o[0] == $past(trunk_core[0]) && client_core[0] == $past(trunk_core[0]))
    else $error("terminal loop not bridged");

  a_adm_squelch: assert property (
    card == plbc_pkg::PLBC_ADD_DROP_CARD && ccfg_reg[`PLBC_CCFG_GE_LSB + 1] &&
    mode_reg[1] == plbc_pkg::PLBC_LOOP_TERMINAL |=> client_tx_o[1] == `PLBC_SQUELCH_FILL)
    else $error("GbE client not squelched");

  // Client terminal fill on the add-drop card replaces the bridged copy
  a_adm_client_ais: assert property (
    card == plbc_pkg::PLBC_ADD_DROP_CARD && !ccfg_reg[`PLBC_CCFG_GE_LSB] &&
    mode_reg[0] == plbc_pkg::PLBC_LOOP_TERMINAL |=> client_tx_o[0] == `PLBC_AIS_FILL)
    else $error("SONET client missing path AIS");

  // Trunk terminal loop keeps the client signal flowing to the span
  a_trunk_term_fwd: assert property (
    mode_reg[TR] == plbc_pkg::PLBC_LOOP_TERMINAL |=> trunk_tx_o[2] == $past(client_core[2]))
    else $error("trunk terminal loop stopped forwarding");

  a_adm_trunk_ais: assert property (
    card == plbc_pkg::PLBC_ADD_DROP_CARD && !ccfg_reg[`PLBC_CCFG_GE_LSB + 3] &&
    mode_reg[TR] == plbc_pkg::PLBC_LOOP_FACILITY |=> client_tx_o[3] == `PLBC_AIS_FILL)
    else $error("SONET client missing AIS");

  a_alarm_masked: assert property (
    mode_reg[TR] != plbc_pkg::PLBC_LOOP_NONE && !alarm_in_loop
    |=> !alarm_o[TR] && alarm_suppressed_maintenance_o[TR])
    else $error("looped trunk alarm not suppressed");

  c_client_fac: cover property (facility_loop_condition_o[0] ##[1:20] !facility_loop_condition_o[0]);
  c_trunk_term: cover property (terminal_loop_condition_o[TR] && loop_complete_o);
  c_adm_fill:   cover property (card == plbc_pkg::PLBC_ADD_DROP_CARD &&
                                facility_loop_condition_o[TR]);
  c_adm_gbe:    cover property (card == plbc_pkg::PLBC_ADD_DROP_CARD &&
                                terminal_loop_condition_o[1]);

endmodule : plbc_loopback_ctrl

// file: verilog/plbc_pkg.sv
/*
  Types of the port loopback controller: loopback modes, service states,
  card kinds and the per-lane steering bundle.
  Assumes plbc_cfg.svh is on the include path.
*/
`include "plbc_cfg.svh"

package plbc_pkg;

  // Gray path: none -> facility -> terminal; 2'b10 is illegal
  typedef enum logic [1:0] {
    PLBC_LOOP_NONE     = 2'b00,
    PLBC_LOOP_FACILITY = 2'b01,
    PLBC_LOOP_TERMINAL = 2'b11
  } plbc_mode_type;

  typedef enum logic [1:0] {
    PLBC_IN_SERVICE_NORMAL_STATE          = 2'b00,
    PLBC_OUT_OF_SERVICE_MAINT_STATE       = 2'b01,
    PLBC_OUT_OF_SERVICE_LOOP_MAINT_STATE  = 2'b11,
    PLBC_OUT_OF_SERVICE_DISABLED_STATE    = 2'b10
  } plbc_svc_type;

  typedef enum logic [1:0] {
    PLBC_TRANSPONDER_CARD = 2'b00,
    PLBC_MUXPONDER_CARD   = 2'b01,
    PLBC_XPONDER_CARD     = 2'b11,
    PLBC_ADD_DROP_CARD    = 2'b10
  } plbc_card_type;

  typedef struct packed {
    plbc_mode_type             mode;
    logic                      fac_bridge;
    logic                      line_fill;
    logic [`PLBC_LANE_W-1:0]   fill;
  } plbc_lane_cfg_type;

endpackage : plbc_pkg

// file: verilog/plbc_rst_sync.sv
/*
  Reset release synchroniser: asynchronous assertion, release after two
  clock edges. Assumes a free-running clock.
*/
`timescale 1ns/1ps

module plbc_rst_sync (
  input  wire logic clock_i,   // System clock
  input  wire logic arst_n_i,  // Raw asynchronous reset
  output logic      rst_n_o    // Synchronised reset
);

  logic meta_reg;

  // First stage feeds only the second
  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      meta_reg <= 1'b0;
      rst_n_o  <= 1'b0;
    end else begin
      meta_reg <= 1'b1;
      rst_n_o  <= meta_reg;
    end
  end

endmodule : plbc_rst_sync
